// ==== rtl/ihc_defines.svh ====
// Offsets, field positions, reset values and bus codes of the interrupt status
// and hardware configuration register bank. Included by the register bank and the testbench.
`ifndef IHC_DEFINES_SVH
`define IHC_DEFINES_SVH

`define IHC_AW 12
`define IHC_OFF_INT_STS 12'h00c
`define IHC_OFF_HARDWARE_CONFIGURATION 12'h010
`define IHC_OFF_IRQ_MASK 12'h014
`define IHC_OFF_EVT_STS 12'h018
`define IHC_OFF_ATTACH_CFG 12'h01c

`define IHC_INT_MAC_ERR 15
`define IHC_INT_USB_TX_FRAME_PENDING 12
`define IHC_INT_GPIO_LO 0
`define IHC_HW_LED_LO 20
`define IHC_HW_DET_STS 15
`define IHC_HW_DET_EN 14
`define IHC_HW_EEM 13
`define IHC_HW_PROTECT 12

`define IHC_EVT_MAC_ERR 0
`define IHC_EVT_GPIO 1
`define IHC_EVT_REATTACH 2
`define IHC_EVT_W 3

`define IHC_RST_LED 4'h0
`define IHC_RST_WORD 32'h0000_0000
`define IHC_RESP_OKAY 2'h0
`define IHC_RESP_SLVERR 2'h2

`endif

// ==== rtl/ihc_pkg.sv ====
// Types shared by the interrupt status and hardware configuration bank.
// Assumes the defines header sits beside it on the include path.
package ihc_pkg;
    typedef enum logic {IHC_ATTACHED, IHC_DETACHED} ihc_link_t;
    typedef logic [31:0] ihc_word_t;
endpackage

// ==== rtl/ihc_regs.sv ====
// Interrupt status and hardware configuration register bank behind AXI4-Lite.
// Assumes all inputs are synchronous to aclk and aresetn is the power-on reset.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ihc_defines.svh"

module ihc_regs
    import ihc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic [`IHC_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`IHC_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] mac_error_status_register,
    input wire logic usb_tx_frame_pending,
    input wire logic [7:0] gpio_in,
    input wire logic phy_link_up,
    input wire logic eeprom_present,
    input wire logic otp_configured,
    output logic [7:0] pin_wake_event,
    output logic [3:0] led_enable,
    output logic usb_detached,
    output logic desc_ram_select,
    output logic irq
);

    logic aw_held_r;
    logic aw_held_nxt;
    logic [`IHC_AW-1:0] awaddr_r;
    logic w_held_r;
    logic w_held_nxt;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_nxt;
    logic rvalid_nxt;
    logic do_wr;
    logic ar_take;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic wr_int;
    logic wr_hw;
    logic wr_mask;
    logic wr_acfg;
    logic rd_evt;
    logic mac_err_r;
    logic err_any;
    logic [7:0] gpio_int_r;
    logic [7:0] gpio_prev_r;
    logic [7:0] gpio_clr;
    logic [7:0] gpio_rise;
    logic [3:0] led_r;
    logic eem_r;
    logic protect_r;
    logic det_sts_r;
    logic det_en_r;
    logic [7:0] attach_cfg_r;
    ihc_link_t link_r;
    logic reattach;
    logic [`IHC_EVT_W-1:0] evt_r;
    logic [`IHC_EVT_W-1:0] evt_set;
    logic [`IHC_EVT_W-1:0] mask_r;
    logic mac_err_prev_r;

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic is_mapped(input logic [`IHC_AW-1:0] a);
        is_mapped = (a == `IHC_OFF_INT_STS) || (a == `IHC_OFF_HARDWARE_CONFIGURATION) ||
            (a == `IHC_OFF_IRQ_MASK) || (a == `IHC_OFF_EVT_STS) ||
            (a == `IHC_OFF_ATTACH_CFG);
    endfunction

    // Write channel: address and data are taken in either order.
    assign do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
    assign bvalid_nxt = do_wr || (s_axi_bvalid && !s_axi_bready);
    assign aw_held_nxt = do_wr ? 1'b0 : (aw_held_r || (s_axi_awvalid && s_axi_awready));
    assign w_held_nxt = do_wr ? 1'b0 : (w_held_r || (s_axi_wvalid && s_axi_wready));
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

    assign wmask = strb_mask(wstrb_r);
    assign wbits = wdata_r & wmask;
    assign wr_int = do_wr && (awaddr_r == `IHC_OFF_INT_STS);
    assign wr_hw = do_wr && (awaddr_r == `IHC_OFF_HARDWARE_CONFIGURATION);
    assign wr_mask = do_wr && (awaddr_r == `IHC_OFF_IRQ_MASK);
    assign wr_acfg = do_wr && (awaddr_r == `IHC_OFF_ATTACH_CFG);
    assign rd_evt = ar_take && (s_axi_araddr == `IHC_OFF_EVT_STS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= `IHC_RST_WORD;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IHC_RESP_OKAY;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_r <= {s_axi_awaddr[`IHC_AW-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
            s_axi_wready <= !w_held_nxt && !bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (do_wr)
            begin
                s_axi_bresp <= is_mapped(awaddr_r) ? `IHC_RESP_OKAY : `IHC_RESP_SLVERR;
            end
        end
    end

    // Read channel: data are registered one cycle after the address is taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `IHC_RST_WORD;
            s_axi_rresp <= `IHC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            if (ar_take)
            begin
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `IHC_RESP_OKAY : `IHC_RESP_SLVERR;
                case ({s_axi_araddr[`IHC_AW-1:2], 2'b00})
                    `IHC_OFF_INT_STS:
                        s_axi_rdata <= {16'h0000, mac_err_r, 2'b00, usb_tx_frame_pending,
                            4'h0, gpio_int_r};
                    `IHC_OFF_HARDWARE_CONFIGURATION:
                        s_axi_rdata <= {8'h00, led_r, 4'h0, det_sts_r, det_en_r, eem_r,
                            protect_r, 12'h000};
                    `IHC_OFF_IRQ_MASK:
                        s_axi_rdata <= {29'h0000_0000, mask_r};
                    `IHC_OFF_EVT_STS:
                        s_axi_rdata <= {29'h0000_0000, evt_r};
                    `IHC_OFF_ATTACH_CFG:
                        s_axi_rdata <= {24'h00_0000, attach_cfg_r};
                    default:
                        s_axi_rdata <= `IHC_RST_WORD;
                endcase
            end
        end
    end

    // MAC error summary is set by the error level and held until cleared; a clear loses to an active error.
    assign err_any = |mac_error_status_register;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_reset)
        begin
            mac_err_r <= 1'b0;
        end
        else
        begin
            mac_err_r <= err_any || (mac_err_r &&
                !(wr_int && wbits[`IHC_INT_MAC_ERR]));
        end
    end

    // Pin interrupts: loaded from the pins at reset, set by level, write-one clear.
    assign gpio_clr = wr_int ? wbits[`IHC_INT_GPIO_LO +: 8] : 8'h00;
    assign gpio_rise = gpio_in & ~gpio_prev_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_reset)
        begin
            gpio_int_r <= gpio_in;
            gpio_prev_r <= gpio_in;
            pin_wake_event <= 8'h00;
        end
        else
        begin
            gpio_int_r <= gpio_in | (gpio_int_r & ~gpio_clr);
            gpio_prev_r <= gpio_in;
            pin_wake_event <= gpio_rise | (pin_wake_event & ~gpio_clr);
        end
    end

    // Protected fields keep their value on a soft reset while protection is set.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            led_r <= `IHC_RST_LED;
            eem_r <= 1'b0;
        end
        else if (soft_reset)
        begin
            if (!protect_r)
            begin
                led_r <= `IHC_RST_LED;
                eem_r <= 1'b0;
            end
        end
        else if (wr_hw)
        begin
            if (wstrb_r[2])
            begin
                led_r <= wdata_r[`IHC_HW_LED_LO +: 4];
            end
            if (wstrb_r[1])
            begin
                eem_r <= wdata_r[`IHC_HW_EEM];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_reset)
        begin
            protect_r <= 1'b0;
        end
        else if (wr_hw && wstrb_r[1])
        begin
            protect_r <= wdata_r[`IHC_HW_PROTECT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            attach_cfg_r <= 8'h00;
            mask_r <= '0;
        end
        else
        begin
            if (wr_acfg && wstrb_r[0])
            begin
                attach_cfg_r <= wdata_r[7:0];
            end
            if (wr_mask && wstrb_r[0])
            begin
                mask_r <= wdata_r[`IHC_EVT_W-1:0];
            end
        end
    end

    // Detach and reattach sequence.
    assign reattach = (link_r == IHC_DETACHED) && (phy_link_up || |(gpio_in & attach_cfg_r));
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_reset)
        begin
            link_r <= IHC_ATTACHED;
            det_en_r <= 1'b0;
            det_sts_r <= 1'b0;
        end
        else
        begin
            det_en_r <= wr_hw && wbits[`IHC_HW_DET_EN];
            case (link_r)
                IHC_ATTACHED:
                    if (det_en_r)
                    begin
                        link_r <= IHC_DETACHED;
                    end
                IHC_DETACHED:
                    if (reattach)
                    begin
                        link_r <= IHC_ATTACHED;
                    end
                default:
                    link_r <= IHC_ATTACHED;
            endcase
            det_sts_r <= reattach ||
                (det_sts_r && !(wr_hw && wbits[`IHC_HW_DET_STS]));
        end
    end

    // Outputs that steer the rest of the device.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            led_enable <= 4'h0;
            usb_detached <= 1'b0;
            desc_ram_select <= 1'b0;
        end
        else
        begin
            led_enable <= led_r;
            usb_detached <= (link_r == IHC_DETACHED);
            desc_ram_select <= eem_r && !eeprom_present && !otp_configured;
        end
    end

    // Sticky events, cleared by reading the event register; a new event wins.
    assign evt_set = {reattach, |gpio_rise, err_any && !mac_err_prev_r};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_r <= '0;
            mac_err_prev_r <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            mac_err_prev_r <= err_any;
            evt_r <= evt_set | (rd_evt ? '0 : evt_r);
            irq <= |(evt_r & mask_r);
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    mac_err_set_a: assert property ((err_any && !soft_reset) |=> mac_err_r)
        else $error("MAC error summary not set by an error bit");
    mac_err_hold_a: assert property (
        (wr_int && wbits[`IHC_INT_MAC_ERR] && err_any && !soft_reset) |=> mac_err_r)
        else $error("MAC error summary cleared while an error was active");
    tx_pending_read_a: assert property (
        (ar_take && s_axi_araddr == `IHC_OFF_INT_STS) |=>
        s_axi_rdata[`IHC_INT_USB_TX_FRAME_PENDING] == $past(usb_tx_frame_pending))
        else $error("Frame pending bit does not match the FIFO state");
    pin_level_a: assert property (
        (!soft_reset && |gpio_in) |=> ((gpio_int_r & $past(gpio_in)) == $past(gpio_in)))
        else $error("Pin interrupt bit not set by an active pin");
    pin_reset_load_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> gpio_int_r == $past(gpio_in))
        else $error("Pin interrupt bits not loaded from the pins at reset");
    wake_clear_a: assert property (
        (|gpio_clr && !soft_reset) |=>
        ((pin_wake_event & $past(gpio_clr) & ~$past(gpio_rise)) == 8'h00))
        else $error("Wake event survived a pin interrupt clear");
    protect_hold_a: assert property (
        (soft_reset && protect_r) |=> ($stable(led_r) && $stable(eem_r)))
        else $error("Protected field changed on a soft reset");
    detach_go_a: assert property (
        (wr_hw && wbits[`IHC_HW_DET_EN] && link_r == IHC_ATTACHED && !soft_reset)
        |=> ##2 usb_detached)
        else $error("Detach enable did not detach the device");
    reattach_a: assert property (
        (reattach && !soft_reset) |=> (link_r == IHC_ATTACHED && det_sts_r))
        else $error("Reattach did not set the detach status");
    desc_gate_a: assert property (
        (eeprom_present || otp_configured) |=> !desc_ram_select)
        else $error("Descriptor select acted with EEPROM or OTP present");

endmodule
`default_nettype wire

// ==== verification/ihc_regs_tb.sv ====
// Self-checking bench for the interrupt status and hardware configuration bank.
// Assumes the design files and ihc_defines.svh are compiled and on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "ihc_defines.svh"

module ihc_regs_tb
    import ihc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic soft_reset = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] mac_err = 32'h0000_0000;
    logic utx = 1'b0, link = 1'b0, eeprom = 1'b0, otp = 1'b0;
    logic [7:0] gpio = 8'h5a;
    logic [7:0] wake;
    logic [3:0] led;
    logic detached, desc_sel, irq;
    logic [31:0] d;
    logic [1:0] r;
    int failures = 0;
    int comparisons = 0;

    always #50 aclk = ~aclk;

    ihc_regs i_dut (
        .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mac_error_status_register(mac_err),
        .usb_tx_frame_pending(utx), .gpio_in(gpio), .phy_link_up(link),
        .eeprom_present(eeprom), .otp_configured(otp), .pin_wake_event(wake),
        .led_enable(led), .usb_detached(detached), .desc_ram_select(desc_sel), .irq(irq)
    );

    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Both channels are offered together and each is released when taken.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        axi_read(a);
        check(d, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge aclk);
    endtask

    task automatic pulse_soft_reset;
        @(posedge aclk);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        settle;
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        close_out;
    end

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        check({led, detached, irq, wake}, 32'h0);
        rd(`IHC_OFF_INT_STS, 32'h0000_005a);
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_0000);
        axi_read(`IHC_OFF_EVT_STS);
        axi_write(`IHC_OFF_IRQ_MASK, 32'h0000_0001);
        @(posedge aclk);
        mac_err <= 32'h0000_0004;
        settle;
        check(irq, 1'b1);
        rd(`IHC_OFF_INT_STS, 32'h0000_805a);
        axi_write(`IHC_OFF_INT_STS, 32'h0000_8000);
        rd(`IHC_OFF_INT_STS, 32'h0000_805a);
        rd(`IHC_OFF_EVT_STS, 32'h0000_0001);
        settle;
        check(irq, 1'b0);
        mac_err <= 32'h0000_0000;
        axi_write(`IHC_OFF_INT_STS, 32'h0000_0000);
        rd(`IHC_OFF_INT_STS, 32'h0000_805a);
        axi_write(`IHC_OFF_INT_STS, 32'h0000_8000);
        rd(`IHC_OFF_INT_STS, 32'h0000_005a);
        axi_write(`IHC_OFF_IRQ_MASK, 32'h0000_0000);
        @(posedge aclk);
        mac_err <= 32'h0000_0100;
        settle;
        check(irq, 1'b0);
        rd(`IHC_OFF_EVT_STS, 32'h0000_0001);
        mac_err <= 32'h0000_0000;
        axi_write(`IHC_OFF_INT_STS, 32'h0000_8000);
        @(posedge aclk);
        gpio <= 8'h5b;
        settle;
        check(wake, 8'h01);
        gpio <= 8'h5a;
        rd(`IHC_OFF_INT_STS, 32'h0000_005b);
        axi_write(`IHC_OFF_INT_STS, 32'h0000_0003);
        rd(`IHC_OFF_INT_STS, 32'h0000_005a);
        check(wake, 8'h00);
        rd(`IHC_OFF_EVT_STS, 32'h0000_0002);
        @(posedge aclk);
        utx <= 1'b1;
        axi_write(`IHC_OFF_INT_STS, 32'h0000_1000);
        rd(`IHC_OFF_INT_STS, 32'h0000_105a);
        utx <= 1'b0;
        rd(`IHC_OFF_INT_STS, 32'h0000_005a);
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'hfff0_2fff);
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h00f0_2000);
        check(led, 4'hf);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge aclk);
            {eeprom, otp} <= i[1:0];
            settle;
            check(desc_sel, i == 0);
        end
        @(posedge aclk);
        {eeprom, otp} <= 2'b00;
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0050_0000);
        settle;
        check({led, desc_sel}, 5'h0a);
        pulse_soft_reset;
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_0000);
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h00a0_3000);
        pulse_soft_reset;
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h00a0_2000);
        check({led, desc_sel}, 5'h15);
        wstrb <= 4'h2;
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_0000);
        wstrb <= 4'hf;
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h00a0_0000);
        check({led, desc_sel}, 5'h14);
        rd(`IHC_OFF_INT_STS, 32'h0000_005a);
        axi_write(`IHC_OFF_ATTACH_CFG, 32'h0000_0001);
        check(r, `IHC_RESP_OKAY);
        rd(`IHC_OFF_ATTACH_CFG, 32'h0000_0001);
        check(r, `IHC_RESP_OKAY);
        axi_read(`IHC_OFF_EVT_STS);
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_4000);
        settle;
        check(detached, 1'b1);
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_0000);
        @(posedge aclk);
        link <= 1'b1;
        settle;
        check(detached, 1'b0);
        link <= 1'b0;
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_8000);
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_8000);
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_0000);
        axi_write(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_4000);
        settle;
        check(detached, 1'b1);
        gpio <= 8'h5b;
        settle;
        check(detached, 1'b0);
        rd(`IHC_OFF_HARDWARE_CONFIGURATION, 32'h0000_8000);
        rd(`IHC_OFF_EVT_STS, 32'h0000_0006);
        rd(12'h020, 32'h0000_0000);
        check(r, `IHC_RESP_SLVERR);
        axi_write(12'h020, 32'hffff_ffff);
        check(r, `IHC_RESP_SLVERR);
        close_out;
    end
endmodule

`default_nettype wire
